//--- src/sdi_pkg.sv
/*
 * Shared constants and types for the stored-data start and direction-inhibit logic.
 * Assumes a single 25 MHz clock domain; all users import the whole package.
 */
package sdi_pkg;

   // Clock rate, kept for reference by anything that derives times.
   localparam int CLK_HZ = 25000000;

   // Widths and counts.
   localparam int NUM_W = 8;
   localparam int DIRECT_N = 8;
   localparam int POS_W = 32;
   localparam int IN_W = 2 * NUM_W + 6;

   // Field positions inside the synchronised input vector.
   localparam int IN_SEL_LSB = 0;
   localparam int IN_DSEL_LSB = 8;
   localparam int IN_FW_INH = 16;
   localparam int IN_RV_INH = 17;
   localparam int IN_BREAK = 18;
   localparam int IN_START = 19;
   localparam int IN_SEQGO = 20;
   localparam int IN_ADVANCE = 21;

   // Link mode of the operation currently in progress, as reported by the data table.
   localparam logic [1:0] LINK_NONE = 2'h0;
   localparam logic [1:0] LINK_MANUAL = 2'h1;
   localparam logic [1:0] LINK_AUTO = 2'h2;
   localparam logic [1:0] LINK_CONT = 2'h3;

   // Inhibit action setting and its value after reset.
   localparam logic INHIBIT_IMMEDIATE = 1'h0;
   localparam logic INHIBIT_DECEL = 1'h1;
   localparam logic INHIBIT_ACT_RESET = 1'h1;

   // Direct-select behaviour setting and its value after reset.
   localparam logic DSEL_SELECT_ONLY = 1'h0;
   localparam logic DSEL_SELECT_START = 1'h1;
   localparam logic DSEL_ACT_RESET = 1'h1;

   // Default direct-select number map: entry i holds i.
   localparam logic [DIRECT_N*NUM_W-1:0] DIRECT_MAP_RESET = 64'h0706050403020100;

   // Values after reset.
   localparam logic [NUM_W-1:0] NUM_RESET = 8'h00;
   localparam logic [POS_W-1:0] POS_RESET = 32'h00000000;
   localparam logic [IN_W-1:0] IN_RESET = 22'h000000;

   typedef enum logic [3:0]
   {
      ST_IDLE = 4'h1,
      ST_LAUNCH = 4'h2,
      ST_RUN = 4'h4,
      ST_STOP = 4'h8
   } sdi_state_t;

endpackage

//--- src/sdi_input_sync.sv
/*
 * Two-flop synchroniser with rising-edge detection for a vector of discrete pins.
 * Assumes the pins are asynchronous to clk and the reset is already synchronised.
 */
`timescale 1ns/100ps

module sdi_input_sync
   import sdi_pkg::*;
#(
   parameter int W = IN_W
)
(
   input wire logic clk, // system clock
   input wire logic rst_n, // synchronised reset, active low
   input wire logic [W-1:0] pin_in, // raw asynchronous pins
   output logic [W-1:0] level_out, // synchronised level
   output logic [W-1:0] rise_out // one-cycle pulse on a rising edge
);

   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] prev_r;

   // The first stage feeds only the second, so no logic ever sees a metastable value.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r <= '0;
         sync_r <= '0;
         prev_r <= '0;
      end
      else
      begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level_out = sync_r;
   // A held input produces one pulse only and never retriggers.
   assign rise_out = sync_r & ~prev_r; // [R18]

endmodule

//--- src/sdi_stored_start.sv
/*
 * Stored-data start, sequencing, direct-select and direction-inhibit stop logic.
 * Assumes a same-clock motion generator that runs launched data, reports motion and answers a direction lookup.
 */
// Behaviour
// [R1] Decel mode: forward inhibit during forward motion requests a deceleration stop.
// [R2] Ready rises once motion has halted after an inhibit stop.
// [R3] With forward inhibit on, reverse starts are accepted; ready drops, motion begins.
// [R4] Releasing inhibit during a deceleration stop does not abort it.
// [R5] Immediate mode halts at the command position latched when inhibit was seen.
// [R6] Sequence break on turns automatic linking into manual linking.
// [R7] Start launches the data number presented beforehand by the host.
// [R8] Start in manual sequence launches the sequence starting number.
// [R9] Sequential go launches next linked number in manual sequence, else selected.
// [R10] Any direct-select input starts positioning with its configured number.
// [R11] Direct-select setting: 0 selects only, 1 selects and starts; default 1.
// [R12] Each direct-select input maps to a number 0..255, default its index.
// [R13] Eight select inputs form an unsigned binary number, bit 0 least significant.
// [R14] Advance during operation jumps at once to the linked next number.
// [R15] Advance with no linked next number is ignored; operation continues.
// [R16] Inhibit action setting: 0 immediate stop, 1 deceleration stop; default 1.
// [R17] Reverse inhibit mirrors forward inhibit for reverse motion and reverse starts.
// [R18] Inputs are synchronised; start-type inputs act on rising edges only.
`timescale 1ns/100ps

module sdi_stored_start
   import sdi_pkg::*;
(
   input wire logic clk, // 25 MHz system clock
   input wire logic rst_n, // asynchronous reset, active low
   input wire logic start_in, // start pin
   input wire logic sequential_go_in, // sequential start pin
   input wire logic sequence_break_in, // sequence break pin
   input wire logic advance_in, // advance to next data pin
   input wire logic forward_inhibit_in, // forward block pin
   input wire logic reverse_inhibit_in, // reverse block pin
   input wire logic [DIRECT_N-1:0] direct_launch_in, // direct-select pins
   input wire logic [NUM_W-1:0] data_number_sel, // data number select pins
   input wire logic inhibit_action, // 0 immediate, 1 deceleration stop
   input wire logic direct_start_enable, // 0 select only, 1 select and start
   input wire logic [DIRECT_N*NUM_W-1:0] direct_number_map, // number per direct input
   input wire logic motion_active, // profile generator is moving
   input wire logic motion_dir_rev, // present motion is reverse
   input wire logic [POS_W-1:0] command_position, // present command position
   input wire logic [1:0] cur_link_mode, // link mode of running data
   input wire logic cur_next_valid, // running data has a linked next number
   input wire logic [NUM_W-1:0] cur_next_number, // linked next number
   input wire logic lookup_dir_rev, // direction of the looked-up number
   output logic [NUM_W-1:0] lookup_number, // candidate number for direction lookup
   output logic launch_pulse, // start data at launch_number
   output logic [NUM_W-1:0] launch_number, // number being launched
   output logic decel_stop_pulse, // request deceleration stop
   output logic immediate_stop_pulse, // request immediate stop at stop_position
   output logic [POS_W-1:0] stop_position, // latched halt position
   output logic ready_out, // idle and able to start
   output logic start_refused, // a start was refused by an inhibit
   output logic auto_link_hold, // automatic linking is held as manual
   output logic [NUM_W-1:0] selected_number, // number a plain start would use outside a manual sequence
   output logic forward_prohibited, // forward inhibit is on
   output logic reverse_prohibited // reverse inhibit is on
);

   logic [1:0] rst_sync_r;
   logic rst_s_n;
   logic [IN_W-1:0] pins;
   logic [IN_W-1:0] lvl;
   logic [IN_W-1:0] rise;
   logic [NUM_W-1:0] dmap [DIRECT_N];
   logic dsel_hit_rise, dsel_hit_lvl;
   logic [NUM_W-1:0] dsel_num_rise, dsel_num_lvl;
   logic fw_on, rv_on;
   logic manual_seq;
   logic [NUM_W-1:0] sel_nxt;
   logic req, req_start;
   logic [NUM_W-1:0] cand;
   logic blocked, accept, advance_go, stop_hit;
   logic [NUM_W-1:0] seq_origin_r;
   sdi_state_t state_r;
   sdi_state_t state_nxt;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rst_sync_r <= 2'h0;
      else
         rst_sync_r <= {rst_sync_r[0], 1'h1};
   end

   assign rst_s_n = rst_sync_r[1];

   assign pins = {advance_in, sequential_go_in, start_in, sequence_break_in,
                  reverse_inhibit_in, forward_inhibit_in, direct_launch_in, data_number_sel};

   sdi_input_sync #(.W(IN_W)) u_sync
   (
      .clk(clk),
      .rst_n(rst_s_n),
      .pin_in(pins),
      .level_out(lvl),
      .rise_out(rise)
   );

   assign fw_on = lvl[IN_FW_INH];
   assign rv_on = lvl[IN_RV_INH];

   for (genvar g = 0; g < DIRECT_N; g++)
   begin : g_map
      assign dmap[g] = direct_number_map[g*NUM_W +: NUM_W]; // [R12]
   end

   // The lowest-numbered direct input wins when several are active together.
   always_comb
   begin
      dsel_hit_rise = 1'h0;
      dsel_num_rise = NUM_RESET;
      dsel_hit_lvl = 1'h0;
      dsel_num_lvl = NUM_RESET;
      for (int i = DIRECT_N - 1; i >= 0; i--)
      begin
         if (rise[IN_DSEL_LSB + i])
         begin
            dsel_hit_rise = 1'h1;
            dsel_num_rise = dmap[i];
         end
         if (lvl[IN_DSEL_LSB + i])
         begin
            dsel_hit_lvl = 1'h1;
            dsel_num_lvl = dmap[i];
         end
      end
   end

   // Break only affects data that would otherwise link automatically.
   assign manual_seq = (cur_link_mode == LINK_MANUAL) ||
                       ((cur_link_mode == LINK_AUTO) && lvl[IN_BREAK]); // [R6]

   // In select-only mode a held direct input replaces the binary selection.
   always_comb
   begin
      if ((direct_start_enable == DSEL_SELECT_ONLY) && dsel_hit_lvl) // [R11]
         sel_nxt = dsel_num_lvl;
      else
         sel_nxt = lvl[IN_SEL_LSB +: NUM_W]; // [R13]
   end

   // One launch per cycle: direct select, then start, then sequential go.
   always_comb
   begin
      req = 1'h0;
      req_start = 1'h0;
      cand = sel_nxt;
      if (dsel_hit_rise && (direct_start_enable == DSEL_SELECT_START))
      begin
         req = 1'h1; // [R10]
         cand = dsel_num_rise;
      end
      else if (rise[IN_START])
      begin
         req = 1'h1;
         req_start = 1'h1;
         if (manual_seq)
            cand = seq_origin_r; // [R8]
         else
            cand = sel_nxt; // [R7]
      end
      else if (rise[IN_SEQGO])
      begin
         req = 1'h1;
         if (manual_seq)
            cand = cur_next_number; // [R9]
         else
            cand = sel_nxt;
      end
   end

   assign lookup_number = cand;
   // Only the start direction that is inhibited is refused; the other one runs.
   assign blocked = lookup_dir_rev ? rv_on : fw_on; // [R3] [R17]
   assign accept = req && (state_r == ST_IDLE) && !blocked;
   assign stop_hit = motion_active && ((fw_on && !motion_dir_rev) || (rv_on && motion_dir_rev)); // [R1] [R17]
   assign advance_go = rise[IN_ADVANCE] && cur_next_valid && (state_r == ST_RUN) && !stop_hit; // [R14] [R15]

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
            if (accept)
               state_nxt = ST_LAUNCH;
         ST_LAUNCH:
            if (stop_hit)
               state_nxt = ST_STOP;
            else if (motion_active)
               state_nxt = ST_RUN;
         ST_RUN:
            if (stop_hit)
               state_nxt = ST_STOP;
            else if (!motion_active)
               state_nxt = ST_IDLE;
         ST_STOP:
            // The inhibit level is no longer looked at here, so a release cannot abort the stop.
            if (!motion_active)
               state_nxt = ST_IDLE; // [R4]
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
         state_r <= ST_IDLE;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
         ready_out <= 1'h0;
      else
         ready_out <= (state_nxt == ST_IDLE); // [R2] [R3]
   end

   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         launch_pulse <= 1'h0;
         launch_number <= NUM_RESET;
      end
      else
      begin
         launch_pulse <= accept || advance_go;
         if (accept)
            launch_number <= cand;
         else if (advance_go)
            launch_number <= cur_next_number; // [R14]
      end
   end

   // A start that is not inside a manual sequence fixes the sequence starting point.
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
         seq_origin_r <= NUM_RESET;
      else if (accept && req_start && !manual_seq)
         seq_origin_r <= cand; // [R8]
   end

   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
         start_refused <= 1'h0;
      else
         start_refused <= req && (state_r == ST_IDLE) && blocked; // [R17]
   end

   // The stop request is raised once, on entry to the stopping state.
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         decel_stop_pulse <= 1'h0;
         immediate_stop_pulse <= 1'h0;
         stop_position <= POS_RESET;
      end
      else
      begin
         decel_stop_pulse <= (state_nxt == ST_STOP) && (state_r != ST_STOP) &&
                             (inhibit_action == INHIBIT_DECEL); // [R1] [R16]
         immediate_stop_pulse <= (state_nxt == ST_STOP) && (state_r != ST_STOP) &&
                                 (inhibit_action == INHIBIT_IMMEDIATE); // [R16]
         if ((state_nxt == ST_STOP) && (state_r != ST_STOP) && (inhibit_action == INHIBIT_IMMEDIATE))
            stop_position <= command_position; // [R5]
      end
   end

   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         auto_link_hold <= 1'h0;
         selected_number <= NUM_RESET;
         forward_prohibited <= 1'h0;
         reverse_prohibited <= 1'h0;
      end
      else
      begin
         auto_link_hold <= (cur_link_mode == LINK_AUTO) && lvl[IN_BREAK]; // [R6]
         selected_number <= sel_nxt;
         forward_prohibited <= fw_on;
         reverse_prohibited <= rv_on;
      end
   end

endmodule

//--- testbench/sdi_monitor.sv
/*
 * Port checker for sdi_stored_start.
 * Bound from the bench top; sees only the top module's ports.
 */
`timescale 1ns/100ps

module sdi_monitor
   import sdi_pkg::*;
(
   input wire logic clk, // clock
   input wire logic rst_n, // reset, active low
   input wire logic launch_pulse, // launch strobe
   input wire logic ready_out, // ready level
   input wire logic decel_stop_pulse, // decel stop
   input wire logic immediate_stop_pulse, // hard stop
   input wire logic inhibit_action, // stop style
   input wire logic [POS_W-1:0] stop_position, // latched position
   input wire logic [POS_W-1:0] command_position, // live position
   input wire logic forward_inhibit_in, // forward pin
   input wire logic forward_prohibited, // forward flag
   input wire logic reverse_inhibit_in, // reverse pin
   input wire logic reverse_prohibited, // reverse flag
   input wire logic start_refused, // refusal strobe
   input wire logic auto_link_hold, // hold flag
   input wire logic [1:0] cur_link_mode, // link mode
   input wire logic motion_active // moving
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   chk_launch_busy: assert property (launch_pulse |-> !ready_out)
      else $error("ready high at launch");
   chk_decel_mode: assert property (decel_stop_pulse |-> $past(inhibit_action))
      else $error("decel stop in immediate mode");
   chk_imm_mode: assert property (immediate_stop_pulse |-> !$past(inhibit_action))
      else $error("immediate stop in decel mode");
   chk_stop_pos: assert property (immediate_stop_pulse |-> stop_position == $past(command_position))
      else $error("stop position not latched");
   chk_fw_sync: assert property ($rose(forward_inhibit_in) |-> ##[1:4] forward_prohibited)
      else $error("forward flag late");
   chk_rv_sync: assert property ($rose(reverse_inhibit_in) |-> ##[1:4] reverse_prohibited)
      else $error("reverse flag late");
   chk_refuse_idle: assert property (start_refused |-> ready_out && !launch_pulse)
      else $error("refusal while busy or launching");
   chk_link_hold: assert property (auto_link_hold |-> $past(cur_link_mode) == LINK_AUTO)
      else $error("hold without auto link");
   chk_ready_end: assert property ($fell(motion_active) && !launch_pulse |-> ##[0:2] ready_out)
      else $error("ready late after halt");
endmodule

//--- testbench/sdi_motion_model.sv
/*
 * Motion generator model behind the block.
 * Numbers with bit 7 set run in reverse; one position step per cycle.
 */
`timescale 1ns/100ps

module sdi_motion_model
   import sdi_pkg::*;
#(
   parameter int RUN = 24,
   parameter int DEC = 6
)
(
   input wire logic clk, // clock
   input wire logic rst_n, // reset, active low
   input wire logic launch_pulse, // launch strobe
   input wire logic [NUM_W-1:0] launch_number, // launched number
   input wire logic decel_stop_pulse, // decel stop
   input wire logic immediate_stop_pulse, // hard stop
   input wire logic [POS_W-1:0] stop_position, // halt position
   input wire logic [NUM_W-1:0] lookup_number, // lookup request
   output logic motion_active, // moving
   output logic motion_dir_rev, // reverse motion
   output logic [POS_W-1:0] command_position, // position
   output logic lookup_dir_rev // lookup answer
);
   int cnt;

   assign lookup_dir_rev = lookup_number[7];

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         motion_active <= 1'h0;
         motion_dir_rev <= 1'h0;
         command_position <= POS_RESET;
         cnt <= 0;
      end
      else if (immediate_stop_pulse)
      begin
         motion_active <= 1'h0;
         command_position <= stop_position;
      end
      else if (launch_pulse)
      begin
         motion_active <= 1'h1;
         motion_dir_rev <= launch_number[7];
         cnt <= RUN;
      end
      else if (decel_stop_pulse && cnt > DEC)
         cnt <= DEC;
      else if (motion_active)
      begin
         cnt <= cnt - 1;
         command_position <= motion_dir_rev ? command_position - 32'h1 : command_position + 32'h1;
         if (cnt == 1)
            motion_active <= 1'h0;
      end
   end
endmodule

//--- testbench/sdi_stored_start_tb.sv
/*
 * Self-checking bench for sdi_stored_start with the motion model.
 * Expected numbers are tracked here from the launch history.
 */
`timescale 1ns/100ps

module sdi_stored_start_tb;
   import sdi_pkg::*;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic start_in = 1'h0, sequential_go_in = 1'h0, sequence_break_in = 1'h0, advance_in = 1'h0;
   logic forward_inhibit_in = 1'h0, reverse_inhibit_in = 1'h0, inhibit_action = 1'h1;
   logic direct_start_enable = 1'h1, cur_next_valid = 1'h0, lp, rf;
   logic [7:0] direct_launch_in = 8'h00, data_number_sel = 8'h00, cur_next_number = 8'h00, v;
   logic [7:0] lookup_number, launch_number, selected_number;
   logic [7:0] sels[3] = '{8'h08, 8'h74, 8'hFF};
   logic [63:0] direct_number_map = DIRECT_MAP_RESET;
   logic [1:0] cur_link_mode = LINK_NONE;
   logic motion_active, motion_dir_rev, lookup_dir_rev, launch_pulse, decel_stop_pulse;
   logic immediate_stop_pulse, ready_out, start_refused, auto_link_hold;
   logic forward_prohibited, reverse_prohibited;
   logic [31:0] command_position, stop_position;
   int n_errors = 0;
   int checked = 0;
   logic [7:0] origin;
   logic [7:0] exp_q[$];

   sdi_stored_start uut (.*);
   sdi_motion_model #(.RUN(24), .DEC(6)) gen (.*);

   initial forever #20 clk = ~clk;

   task close_out();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      #400000;
      n_errors++;
      close_out();
   end

   // Every launch must be one the bench asked for; sampled mid-cycle while the pulse stands.
   always @(negedge clk)
   begin
      if (launch_pulse === 1'h1)
      begin
         chk("queued launch", exp_q.size() != 0, 1'h1);
         if (exp_q.size() != 0)
            chk("queued number", launch_number, exp_q.pop_front());
      end
   end

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task pin(input int k, input logic b);
      case (k)
         0: start_in = b;
         1: sequential_go_in = b;
         2: advance_in = b;
         default: direct_launch_in[k-3] = b;
      endcase
   endtask

   // Holds the pin until an answer or eight cycles, then lets it rest low.
   task fire(input int k, input logic ok, input logic [7:0] exp);
      lp = 1'h0;
      rf = 1'h0;
      if (ok)
         exp_q.push_back(exp);
      pin(k, 1'h1);
      for (int i = 0; i < 8 && lp !== 1'h1 && rf !== 1'h1; i++)
      begin
         step(1);
         lp = launch_pulse;
         rf = start_refused;
      end
      pin(k, 1'h0);
      chk("launch", lp, ok);
      if (ok)
         chk("number", launch_number, exp);
      step(3);
   endtask

   task idle();
      for (int i = 0; i < 60 && ready_out !== 1'h1; i++)
         step(1);
      chk("ready", ready_out, 1'h1);
   endtask

   task await_stop(input logic imm);
      for (int i = 0; i < 8 && (imm ? immediate_stop_pulse : decel_stop_pulse) !== 1'h1; i++)
         step(1);
      chk("stop", imm ? immediate_stop_pulse : decel_stop_pulse, 1'h1);
   endtask

   initial
   begin
      void'($urandom(32'h435f));
      step(2);
      chk("ready in reset", ready_out, 1'h0);
      step(10);
      rst_n = 1'h1;
      step(6);
      chk("ready after reset", ready_out, 1'h1);
      $display("test reset done");
      for (int i = 0; i < 6; i++)
      begin
         v = (i < 3) ? sels[i] : 8'($urandom);
         data_number_sel = v;
         origin = v;
         step(2);
         fire(0, 1'h1, v);
         idle();
      end
      $display("test select done");
      for (int j = 0; j < 2; j++)
      begin
         if (j == 1)
            direct_number_map = {$urandom, $urandom};
         for (int i = 0; i < 8; i++)
         begin
            fire(3 + i, 1'h1, direct_number_map[8*i+:8]);
            idle();
         end
      end
      direct_start_enable = 1'h0;
      fire(8, 1'h0, 8'h00);
      direct_launch_in[5] = 1'h1;
      step(4);
      chk("selected", selected_number, direct_number_map[47:40]);
      fire(0, 1'h1, direct_number_map[47:40]);
      origin = direct_number_map[47:40];
      direct_launch_in[5] = 1'h0;
      direct_start_enable = 1'h1;
      idle();
      $display("test direct done");
      data_number_sel = 8'h11;
      cur_link_mode = LINK_MANUAL;
      cur_next_number = 8'h33;
      step(2);
      fire(0, 1'h1, origin);
      idle();
      fire(1, 1'h1, 8'h33);
      idle();
      cur_link_mode = LINK_AUTO;
      sequence_break_in = 1'h1;
      step(5);
      chk("hold", auto_link_hold, 1'h1);
      fire(1, 1'h1, 8'h33);
      idle();
      sequence_break_in = 1'h0;
      step(5);
      fire(1, 1'h1, 8'h11);
      idle();
      $display("test sequence done");
      // Continuous linking is where advance is used; a start there still takes the selection.
      cur_link_mode = LINK_CONT;
      cur_next_valid = 1'h1;
      cur_next_number = 8'h22;
      data_number_sel = 8'h05;
      step(2);
      fire(0, 1'h1, 8'h05);
      fire(2, 1'h1, 8'h22);
      cur_next_valid = 1'h0;
      fire(2, 1'h0, 8'h00);
      chk("busy", ready_out, 1'h0);
      idle();
      $display("test advance done");
      fire(0, 1'h1, 8'h05);
      forward_inhibit_in = 1'h1;
      await_stop(1'h0);
      forward_inhibit_in = 1'h0;
      step(4);
      chk("still moving", ready_out, 1'h0);
      idle();
      forward_inhibit_in = 1'h1;
      step(4);
      fire(0, 1'h0, 8'h00);
      chk("refused", rf, 1'h1);
      data_number_sel = 8'h85;
      step(2);
      fire(0, 1'h1, 8'h85);
      idle();
      forward_inhibit_in = 1'h0;
      $display("test decel done");
      inhibit_action = 1'h0;
      fire(0, 1'h1, 8'h85);
      reverse_inhibit_in = 1'h1;
      await_stop(1'h1);
      idle();
      fire(0, 1'h0, 8'h00);
      chk("refused", rf, 1'h1);
      reverse_inhibit_in = 1'h0;
      inhibit_action = 1'h1;
      $display("test immediate done");
      close_out();
   end
endmodule

bind sdi_stored_start sdi_monitor mon (.*);
